// [core/blank_timer.sv]
// Receive blanking timer: counts programmed steps after each transmit end of frame
module blank_timer
(
    input  wire logic     i_mclk,
    input  wire logic     i_rst_b,
    blank_timer_if.timer  bus
);

    typedef struct packed {
        logic       active;
        logic [9:0] cnt;
        logic [7:0] steps;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (bus.clear)
        begin
            state_next = '0;
        end
        else if (bus.tx_eof)
        begin
            // A new frame end restarts the interval; zero means no blanking
            state_next.active = (bus.value != 8'h00); // [RL1]
            state_next.cnt    = 10'h000;
            state_next.steps  = bus.value; // [RL3]
        end
        else if (state_reg.active)
        begin
            if (state_reg.cnt == rx_blank_mod_pkg::STEP_LAST) // [RL2]
            begin
                state_next.cnt   = 10'h000;
                state_next.steps = state_reg.steps - 8'h01;
                if (state_reg.steps == 8'h01)
                begin
                    state_next.active = 1'b0; // [RL14]
                end
            end
            else
            begin
                state_next.cnt = state_reg.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bus.active = state_reg.active;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    blank_start_a: assert property (bus.tx_eof && !bus.clear && bus.value != 8'h00 |=> bus.active [*8]) // [RL1]
        else $error("blanking did not start after frame end");
    step_len_a: assert property (state_reg.active && !bus.tx_eof && !bus.clear && state_reg.cnt == 10'h000
                                 && state_reg.steps > 8'h01
                                 |=> (state_reg.steps == $past(state_reg.steps)) [*8]) // [RL2]
        else $error("blanking step shorter than expected");
    steps_nonzero_a: assert property (state_reg.active |-> state_reg.steps != 8'h00) // [RL3]
        else $error("blanking active with zero steps");
    release_a: assert property (state_reg.active && !bus.tx_eof && !bus.clear && state_reg.steps == 8'h01
                                && state_reg.cnt == rx_blank_mod_pkg::STEP_LAST |=> !bus.active) // [RL14]
        else $error("decoders not released at interval end");

    restart_c: cover property (bus.tx_eof && state_reg.active);
    expire_c: cover property ($fell(state_reg.active) && !$past(bus.clear) && !$past(bus.tx_eof));

endmodule

// [core/blank_timer_if.sv]
// Link between the control registers and the receive blanking timer
interface blank_timer_if;
    logic       tx_eof;
    logic [7:0] value;
    logic       clear;
    logic       active;

    modport timer (input tx_eof, input value, input clear, output active);
    modport ctrl  (output tx_eof, output value, output clear, input active);
endinterface

// [core/rx_blank_mod_pkg.sv]
// Constants shared by the receive blanking timer and the modulator control block
package rx_blank_mod_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned BLANK_STEP_NS      = 9440;
    localparam int unsigned BLANK_STEP_CYCLES  = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CNT_W         = 10;
    localparam logic [9:0]  STEP_LAST          = 10'(BLANK_STEP_CYCLES - 1);
    localparam int unsigned ISO_MIN_RESP_NS    = 66000;
    localparam int unsigned PROP_MIN_RESP_NS   = 9440;
    localparam logic [7:0]  BLANK_PRESET_ISO   = 8'((ISO_MIN_RESP_NS + BLANK_STEP_NS - 1) / BLANK_STEP_NS);
    localparam logic [7:0]  BLANK_PRESET_PROP  = 8'((PROP_MIN_RESP_NS + BLANK_STEP_NS - 1) / BLANK_STEP_NS);

    // Bus
    localparam int unsigned ADDR_W             = 6;
    localparam logic [3:0]  REG_IDX_PROTOCOL   = 4'h1;
    localparam logic [3:0]  REG_IDX_BLANK      = 4'h8;
    localparam logic [3:0]  REG_IDX_MOD        = 4'h9;
    localparam logic [3:0]  REG_IDX_STATUS     = 4'ha;

    // Values after reset and modulator register masks
    localparam logic [7:0]  PROTOCOL_RESET     = 8'h00;
    localparam logic [7:0]  BLANK_RESET        = 8'h1f;
    localparam logic [7:0]  MOD_RESET          = 8'h11;
    localparam logic [7:0]  MOD_READ_MASK      = 8'h7f;
    localparam logic [7:0]  MOD_CLK_MASK       = 8'h30;

    // Field positions
    localparam int unsigned MOD_OOK_PIN_EN_BIT = 6;
    localparam int unsigned MOD_CLK_SEL_LO     = 4;
    localparam int unsigned MOD_ANALOG_BIT     = 3;
    localparam int unsigned PROTO_OOK_EN_BIT   = 6;
    localparam int unsigned PROTO_PROP_BIT     = 5;

    // Pin positions in the synchroniser vector
    localparam int unsigned PIN_ENABLE         = 0;
    localparam int unsigned PIN_OOK            = 1;
    localparam int unsigned PIN_MOD            = 2;
    localparam int unsigned PIN_OSC            = 3;

    // Modulation depth codes
    localparam logic [2:0]  DEPTH_ASK_10       = 3'h0;
    localparam logic [2:0]  DEPTH_OOK          = 3'h1;
    localparam logic [2:0]  DEPTH_ASK_7        = 3'h2;
    localparam logic [2:0]  DEPTH_ASK_8P5      = 3'h3;
    localparam logic [2:0]  DEPTH_ASK_13       = 3'h4;

    // Clock output select codes
    localparam logic [1:0]  CLK_SEL_OFF        = 2'h0;
    localparam logic [1:0]  CLK_SEL_DIV4       = 2'h1;
    localparam logic [1:0]  CLK_SEL_DIV2       = 2'h2;
    localparam logic [1:0]  CLK_SEL_DIV1       = 2'h3;

endpackage

// [core/rx_blanking_and_modulator_control.sv]
// Receive blanking and modulator / clock output control with an Avalon-MM register slave
//
// What this block does
// [RL1] After each transmit frame end, hold receive decoders in reset for the blanking interval.
// [RL2] Blanking interval equals register value times a 9.44 us step.
// [RL3] Register values 1 to 255 give one step up to about 2.4 ms.
// [RL4] Blanking register becomes 0x1f at reset and while chip enable is low.
// [RL5] Protocol write presets blanking: 66 us for ISO types, one step proprietary.
// [RL6] Clock output is the oscillator divided by 1, 2 or 4 per bits 5:4.
// [RL7] Clock select 00 off, 01 divide by 4, 10 divide by 2, 11 undivided.
// [RL8] Modulation depth comes from bits 2:0 of the modulator register.
// [RL9] Depths from 7 to 30 percent ASK plus 100 percent OOK are supported.
// [RL10] Depth codes: 000 ASK10, 001 OOK, 010 ASK7, 011 ASK8.5, 100 ASK13.
// [RL11] OOK pin acts only when modulator bit 6 and protocol bit 6 are set.
// [RL12] With pin control on, pin high selects OOK, low the programmed ASK depth.
// [RL13] With pin control on, the modulation pin carries the modulation input.
// [RL14] Decoders leave reset on the cycle after the interval expires.
module rx_blanking_and_modulator_control
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_chip_enable,
    input  wire logic        i_tx_eof,
    input  wire logic        i_ook_pin,
    input  wire logic        i_modulation_input_pin,
    input  wire logic        i_oscillator,
    output logic             o_rx_decoder_reset,
    output logic             o_divided_clock_output,
    output logic      [2:0]  o_mod_depth,
    output logic             o_tx_modulation,
    output logic             o_analog_out_en
);

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic        osc_prev;
        logic        div2;
        logic        div4;
        logic        clk_out;
        logic [7:0]  protocol;
        logic [7:0]  blank;
        logic [7:0]  modctl;
        logic [2:0]  depth_out;
        logic        tx_mod;
        logic        analog;
        logic        ack;
        logic        waitreq;
        logic [31:0] rdata;
    } ctrl_state_t;

    ctrl_state_t   state_reg;
    ctrl_state_t   state_next;
    blank_timer_if blk ();

    logic       req;
    logic       commit;
    logic       wr;
    logic       en;
    logic       ext_ook;
    logic       osc_rise;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] status;

    blank_timer u_blank_timer
    (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .bus     (blk.timer)
    );

    assign blk.tx_eof = i_tx_eof & state_reg.sync2[rx_blank_mod_pkg::PIN_ENABLE]; // [RL1]
    assign blk.value  = state_reg.blank; // [RL2]
    assign blk.clear  = ~state_reg.sync2[rx_blank_mod_pkg::PIN_ENABLE];

    always_comb
    begin
        state_next = state_reg;
        req        = i_avs_read | i_avs_write;
        idx        = i_avs_address[5:2];
        // A request commits at the edge where waitrequest is seen low
        commit     = req & state_reg.ack;
        wr         = i_avs_write & commit & i_avs_byteenable[0];
        wdata      = i_avs_writedata[7:0];
        en         = state_reg.sync2[rx_blank_mod_pkg::PIN_ENABLE];
        ext_ook    = state_reg.modctl[rx_blank_mod_pkg::MOD_OOK_PIN_EN_BIT]
                     & state_reg.protocol[rx_blank_mod_pkg::PROTO_OOK_EN_BIT]; // [RL11]
        osc_rise   = state_reg.sync2[rx_blank_mod_pkg::PIN_OSC] & ~state_reg.osc_prev;
        status     = {4'h0, ext_ook, blk.active,
                      state_reg.sync2[rx_blank_mod_pkg::PIN_MOD],
                      state_reg.sync2[rx_blank_mod_pkg::PIN_OOK]};

        // Pins from outside the clock domain pass two flip-flops
        state_next.sync1 = {i_oscillator, i_modulation_input_pin, i_ook_pin, i_chip_enable};
        state_next.sync2 = state_reg.sync1;

        // One wait state per access, then a single cycle with waitrequest low
        state_next.ack     = req & ~state_reg.ack;
        state_next.waitreq = ~(req & ~state_reg.ack);
        if (req && !state_reg.ack)
        begin
            case (idx)
                rx_blank_mod_pkg::REG_IDX_PROTOCOL: state_next.rdata = {24'h000000, state_reg.protocol};
                rx_blank_mod_pkg::REG_IDX_BLANK:    state_next.rdata = {24'h000000, state_reg.blank};
                rx_blank_mod_pkg::REG_IDX_MOD:
                    state_next.rdata = {24'h000000, state_reg.modctl & rx_blank_mod_pkg::MOD_READ_MASK};
                rx_blank_mod_pkg::REG_IDX_STATUS:   state_next.rdata = {24'h000000, status};
                default:                            state_next.rdata = 32'h00000000;
            endcase
        end

        // Enable low holds every register at its preset; writes are lost meanwhile
        if (!en)
        begin
            state_next.protocol = rx_blank_mod_pkg::PROTOCOL_RESET;
            state_next.blank    = rx_blank_mod_pkg::BLANK_RESET; // [RL4]
            state_next.modctl   = rx_blank_mod_pkg::MOD_RESET;
        end
        else if (wr)
        begin
            case (idx)
                rx_blank_mod_pkg::REG_IDX_PROTOCOL:
                begin
                    state_next.protocol = wdata;
                    if (wdata[rx_blank_mod_pkg::PROTO_PROP_BIT])
                    begin
                        state_next.blank = rx_blank_mod_pkg::BLANK_PRESET_PROP; // [RL5]
                    end
                    else
                    begin
                        state_next.blank = rx_blank_mod_pkg::BLANK_PRESET_ISO; // [RL5]
                    end
                    // Clock select survives a protocol change so the host clock does not stop
                    state_next.modctl = (rx_blank_mod_pkg::MOD_RESET & ~rx_blank_mod_pkg::MOD_CLK_MASK)
                                        | (state_reg.modctl & rx_blank_mod_pkg::MOD_CLK_MASK);
                end
                rx_blank_mod_pkg::REG_IDX_BLANK: state_next.blank  = wdata; // [RL3]
                rx_blank_mod_pkg::REG_IDX_MOD:   state_next.modctl = wdata & rx_blank_mod_pkg::MOD_READ_MASK;
                default:                         state_next.blank  = state_reg.blank;
            endcase
        end

        // Divided clock; sampling the oscillator at 100 MHz adds up to one cycle of jitter
        state_next.osc_prev = state_reg.sync2[rx_blank_mod_pkg::PIN_OSC];
        if (osc_rise)
        begin
            state_next.div2 = ~state_reg.div2;
            if (state_reg.div2)
            begin
                state_next.div4 = ~state_reg.div4;
            end
        end
        case (state_reg.modctl[rx_blank_mod_pkg::MOD_CLK_SEL_LO +: 2]) // [RL6]
            rx_blank_mod_pkg::CLK_SEL_OFF:  state_next.clk_out = 1'b0; // [RL7]
            rx_blank_mod_pkg::CLK_SEL_DIV4: state_next.clk_out = state_reg.div4; // [RL7]
            rx_blank_mod_pkg::CLK_SEL_DIV2: state_next.clk_out = state_reg.div2; // [RL7]
            rx_blank_mod_pkg::CLK_SEL_DIV1: state_next.clk_out = state_reg.sync2[rx_blank_mod_pkg::PIN_OSC]; // [RL7]
            default:                        state_next.clk_out = 1'b0;
        endcase

        // Codes 5 to 7 pass through unchanged to the modulator
        if (ext_ook && state_reg.sync2[rx_blank_mod_pkg::PIN_OOK])
        begin
            state_next.depth_out = rx_blank_mod_pkg::DEPTH_OOK; // [RL12]
        end
        else
        begin
            state_next.depth_out = state_reg.modctl[2:0]; // [RL8] [RL9] [RL10]
        end
        state_next.tx_mod = ext_ook & state_reg.sync2[rx_blank_mod_pkg::PIN_MOD]; // [RL13]
        state_next.analog = state_reg.modctl[rx_blank_mod_pkg::MOD_ANALOG_BIT];
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg          <= '0;
            state_reg.protocol <= rx_blank_mod_pkg::PROTOCOL_RESET;
            state_reg.blank    <= rx_blank_mod_pkg::BLANK_RESET; // [RL4]
            state_reg.modctl   <= rx_blank_mod_pkg::MOD_RESET;
            state_reg.waitreq  <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_avs_readdata         = state_reg.rdata;
    assign o_avs_waitrequest      = state_reg.waitreq;
    assign o_rx_decoder_reset     = blk.active;
    assign o_divided_clock_output = state_reg.clk_out;
    assign o_mod_depth            = state_reg.depth_out;
    assign o_tx_modulation        = state_reg.tx_mod;
    assign o_analog_out_en        = state_reg.analog;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    enable_preset_a: assert property (!en |=> state_reg.blank == 8'h1f) // [RL4]
        else $error("blanking register not preset while enable low");
    prop_preset_a: assert property (en && wr && idx == rx_blank_mod_pkg::REG_IDX_PROTOCOL
                                    && wdata[rx_blank_mod_pkg::PROTO_PROP_BIT] |=> state_reg.blank == 8'h01) // [RL5]
        else $error("proprietary preset of blanking register wrong");
    iso_preset_a: assert property (en && wr && idx == rx_blank_mod_pkg::REG_IDX_PROTOCOL
                                   && !wdata[rx_blank_mod_pkg::PROTO_PROP_BIT] |=> state_reg.blank == 8'h07) // [RL5]
        else $error("ISO preset of blanking register wrong");
    clk_off_a: assert property (state_reg.modctl[5:4] == 2'h0 |=> !o_divided_clock_output) // [RL7]
        else $error("clock output not disabled");
    clk_div1_a: assert property (state_reg.modctl[5:4] == 2'h3
                                 |=> o_divided_clock_output == $past(state_reg.sync2[rx_blank_mod_pkg::PIN_OSC])) // [RL6]
        else $error("undivided clock output wrong");
    depth_field_a: assert property (!ext_ook |=> o_mod_depth == $past(state_reg.modctl[2:0])) // [RL8]
        else $error("depth output does not follow register field");
    pin_ook_a: assert property (ext_ook && state_reg.sync2[rx_blank_mod_pkg::PIN_OOK]
                                |=> o_mod_depth == 3'h1) // [RL12]
        else $error("OOK pin high did not select OOK");
    pin_gate_a: assert property (o_mod_depth == 3'h1 && $past(state_reg.modctl[2:0]) != 3'h1
                                 |-> $past(ext_ook)) // [RL11]
        else $error("OOK selected by pin without both enables");
    mod_input_a: assert property (##1 o_tx_modulation
                                  |-> $past(ext_ook) && $past(state_reg.sync2[rx_blank_mod_pkg::PIN_MOD])) // [RL13]
        else $error("modulation output without pin control");
    wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    proto_write_c: cover property (en && wr && idx == rx_blank_mod_pkg::REG_IDX_PROTOCOL);
    pin_ook_c: cover property (ext_ook && state_reg.sync2[rx_blank_mod_pkg::PIN_OOK]);
    div4_c: cover property (state_reg.modctl[5:4] == 2'h1 && $rose(o_divided_clock_output));

endmodule

// [test/host_model.sv]
// Host microcontroller model: Avalon-MM master doing single register accesses
module host_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output logic      [5:0]  o_address,
    output logic             o_read,
    output logic             o_write,
    output logic      [31:0] o_writedata,
    output logic      [3:0]  o_byteenable
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        o_address = 6'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'h0;
    end

    // Called just after a rising edge; the request holds until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] data,
                        input logic [3:0] be, output logic [31:0] rdata, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 32'h0;
        o_address <= addr;
        o_write <= wr;
        o_read <= !wr;
        o_writedata <= {24'h0, data};
        o_byteenable <= be;
        // Waitrequest and read data are taken at the rising edge, before the slave updates them
        while (!ok && n < 64)
        begin
            @(posedge i_mclk);
            n++;
            if (i_waitrequest === 1'b0)
            begin
                ok = 1'b1;
                rdata = i_readdata;
            end
        end
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

// [test/rx_blanking_and_modulator_control_tb.sv]
// Self-checking bench for the receive blanking and modulator control block
module rx_blanking_and_modulator_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {logic [5:0] addr; logic [7:0] data; logic [3:0] be; logic [7:0] exp;} row_t;

    logic        mclk, rst_b, chip_enable, tx_eof, ook_pin, mod_pin;
    logic        osc = 1'b0;
    logic [5:0]  address;
    logic        read, write, waitrequest, rx_reset, div_clk, tx_mod, analog;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [2:0]  depth;
    int          bad_count, tests_run;
    int          osc_acc = 0;
    row_t        rows[5] = '{'{6'h20, 8'h05, 4'h1, 8'h05}, '{6'h20, 8'h44, 4'h0, 8'h05},
                            '{6'h24, 8'hff, 4'h1, 8'h7f}, '{6'h24, 8'h00, 4'h1, 8'h00},
                            '{6'h3c, 8'h12, 4'h1, 8'h00}};

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Oscillator at 13.56 MHz from a phase accumulator, so it moves only on clock edges
    always @(posedge mclk)
    begin
        if (osc_acc + 2712 >= 10000)
        begin
            osc <= ~osc;
            osc_acc <= osc_acc + 2712 - 10000;
        end
        else
            osc_acc <= osc_acc + 2712;
    end

    rx_blanking_and_modulator_control dut
    (
        .i_mclk(mclk), .i_rst_b(rst_b), .i_avs_address(address), .i_avs_read(read),
        .i_avs_write(write), .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .i_chip_enable(chip_enable),
        .i_tx_eof(tx_eof), .i_ook_pin(ook_pin), .i_modulation_input_pin(mod_pin), .i_oscillator(osc),
        .o_rx_decoder_reset(rx_reset), .o_divided_clock_output(div_clk), .o_mod_depth(depth),
        .o_tx_modulation(tx_mod), .o_analog_out_en(analog)
    );

    host_model host
    (
        .i_mclk(mclk), .i_waitrequest(waitrequest), .i_readdata(readdata), .o_address(address),
        .o_read(read), .o_write(write), .o_writedata(writedata), .o_byteenable(byteenable)
    );

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] addr, input logic [7:0] data,
                       input logic [3:0] be, output logic [31:0] rd);
        logic ok;
        @(posedge mclk);
        host.xfer(wr, addr, data, be, rd, ok);
        if (!ok)
        begin
            bad_count++;
            $display("FAIL bus answer expected 0 seen 1");
            summarize();
        end
    endtask

    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        logic [31:0] r;
        bus(1'b1, addr, data, 4'h1, r);
    endtask

    task automatic rd_check(input string name, input logic [5:0] addr, input logic [7:0] exp);
        logic [31:0] r;
        bus(1'b0, addr, 8'h00, 4'h1, r);
        check(name, {24'h0, exp}, r);
    endtask

    task automatic blank_len(input int v);
        int n;
        n = 0;
        wr(6'h20, 8'(v));
        @(posedge mclk);
        tx_eof <= 1'b1;
        @(posedge mclk);
        tx_eof <= 1'b0;
        @(negedge mclk);
        while (rx_reset === 1'b1 && n < 5000)
        begin
            n++;
            @(negedge mclk);
        end
        check("blanking cycles", 32'(944 * v), 32'(n));
    endtask

    task automatic clk_rate(input logic [1:0] sel, input int exp);
        int   n;
        logic prev;
        n = 0;
        wr(6'h24, {2'b00, sel, 4'h1});
        repeat (20) @(posedge mclk);
        prev = div_clk;
        repeat (2000)
        begin
            @(negedge mclk);
            if (div_clk === 1'b1 && prev === 1'b0)
                n++;
            prev = div_clk;
        end
        // Sampling at 100 MHz jitters the count by an edge or two
        check("clock out edges in range", 1, 32'(n >= exp - 3 && n <= exp + 3));
    endtask

    task automatic pins(input logic ook, input logic md, input logic [2:0] exp_depth, input logic exp_mod);
        @(posedge mclk);
        ook_pin <= ook;
        mod_pin <= md;
        repeat (5) @(posedge mclk);
        check("depth with pin", {29'h0, exp_depth}, {29'h0, depth});
        check("tx modulation", {31'h0, exp_mod}, {31'h0, tx_mod});
        check("analog disable", 32'h0, {31'h0, analog});
    endtask

    initial
    begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        $display("FAIL run length expected done seen hang");
        summarize();
    end

    initial
    begin
        rst_b = 1'b0;
        chip_enable = 1'b1;
        tx_eof = 1'b0;
        ook_pin = 1'b0;
        mod_pin = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_check("blanking reset", 6'h20, 8'h1f);
        rd_check("modulator reset", 6'h24, 8'h11);
        rd_check("protocol reset", 6'h04, 8'h00);
        check("depth reset", 32'h1, {29'h0, depth});
        $display("test reset done");
        foreach (rows[i])
        begin
            logic [31:0] r;
            bus(1'b1, rows[i].addr, rows[i].data, rows[i].be, r);
            rd_check("register row", rows[i].addr, rows[i].exp);
        end
        $display("test register rows done");
        for (int c = 0; c < 5; c++)
        begin
            wr(6'h24, {5'h03, 3'(c)});
            repeat (3) @(posedge mclk);
            check("depth code", 32'(c), {29'h0, depth});
            check("analog enable", 32'h1, {31'h0, analog});
        end
        $display("test depth codes done");
        blank_len(1);
        blank_len(2);
        blank_len(0);
        $display("test blanking done");
        wr(6'h24, 8'h35);
        wr(6'h04, 8'h00);
        rd_check("iso blanking preset", 6'h20, 8'h07);
        rd_check("modulator preset", 6'h24, 8'h31);
        wr(6'h04, 8'h20);
        rd_check("fast blanking preset", 6'h20, 8'h01);
        $display("test protocol preset done");
        clk_rate(2'h0, 0);
        clk_rate(2'h1, 68);
        clk_rate(2'h2, 136);
        clk_rate(2'h3, 271);
        $display("test clock output done");
        wr(6'h04, 8'h40);
        wr(6'h24, 8'h70);
        pins(1'b1, 1'b1, 3'h1, 1'b1);
        rd_check("status pins", 6'h28, 8'h0b);
        pins(1'b0, 1'b0, 3'h0, 1'b0);
        pins(1'b0, 1'b1, 3'h0, 1'b1);
        wr(6'h24, 8'h30);
        pins(1'b1, 1'b1, 3'h0, 1'b0);
        wr(6'h04, 8'h00);
        wr(6'h24, 8'h70);
        pins(1'b1, 1'b1, 3'h0, 1'b0);
        $display("test pin control done");
        wr(6'h20, 8'h33);
        @(posedge mclk);
        chip_enable <= 1'b0;
        repeat (5) @(posedge mclk);
        chip_enable <= 1'b1;
        repeat (5) @(posedge mclk);
        rd_check("blanking after enable low", 6'h20, 8'h1f);
        $display("test enable low done");
        summarize();
    end
endmodule
